//--- rtl/ivp_pkg.sv
// ivp_pkg: constants for interrupt vector placement block
// assumes: word addressed program flash, 8-bit control register on an axi4-lite slave
package ivp_pkg;
  localparam int ivp_addr_w = 16;
  // register byte offsets
  localparam logic [7:0] ivp_off_ctrl = 8'h00;
  localparam logic [7:0] ivp_off_fuse = 8'h04;
  localparam logic [7:0] ivp_off_vec = 8'h08;
  localparam logic [7:0] ivp_off_stat = 8'h0c;
  localparam logic [7:0] ivp_off_pc = 8'h10;
  // control register fields
  localparam int ivp_bit_unlock = 0;
  localparam int ivp_bit_select = 1;
  localparam logic [7:0] ivp_ctrl_rst = 8'h00;
  // fuse register fields
  localparam int ivp_bit_boot_reset_fuse_fuse = 0;
  localparam int ivp_pos_boot_size_fuses = 1;
  localparam int ivp_bit_app_lock = 3;
  localparam int ivp_bit_boot_lock = 4;
  localparam logic [7:0] ivp_fuse_rst = 8'h07;
  // vector table
  localparam logic [15:0] ivp_vec_first = 16'h0002;
  localparam logic [15:0] ivp_vec_cmp_d = 16'h0050;
  localparam logic [15:0] ivp_vec_ovf = 16'h0052;
  localparam logic [15:0] ivp_vec_fault = 16'h0054;
  localparam logic [15:0] ivp_flash_start = 16'h0000;
  // unlock window length in cycles
  localparam logic [2:0] ivp_unlock_cycles = 3'h4;
  // boot section start per boot size code
  function automatic logic [15:0] ivp_boot_start(input logic [1:0] sz);
    unique case (sz)
      2'h0: ivp_boot_start = 16'h3800;
      2'h1: ivp_boot_start = 16'h3c00;
      2'h2: ivp_boot_start = 16'h3e00;
      default: ivp_boot_start = 16'h3f00;
    endcase
  endfunction : ivp_boot_start
endpackage : ivp_pkg

//--- rtl/ivp_unlock.sv
// ivp_unlock: timed unlock sequence for vector base select
// assumes: ctrl write strobe and data come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module ivp_unlock (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic instr_done,
  output logic unlock,
  output logic select,
  output logic block
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic next_unlock;
  logic next_select;
  logic post;
  logic next_post;

  always_comb begin
    next_unlock = unlock;
    next_select = select;
    next_cnt = cnt;
    next_post = post;
    if (post && instr_done) begin
      next_post = 1'b0;
    end
    if (unlock) begin
      next_cnt = 3'(cnt - 3'h1);
      if (cnt == 3'h1) begin
        next_unlock = 1'b0;
      end
    end
    if (wr) begin
      if (unlock && !wdata[ivp_pkg::ivp_bit_unlock]) begin
        next_select = wdata[ivp_pkg::ivp_bit_select];
        next_unlock = 1'b0;
        next_cnt = 3'h0;
        next_post = 1'b1;
      end else if (wdata[ivp_pkg::ivp_bit_unlock]) begin
        next_unlock = 1'b1;
        next_cnt = ivp_pkg::ivp_unlock_cycles;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      unlock <= 1'b0;
      select <= ivp_pkg::ivp_ctrl_rst[ivp_pkg::ivp_bit_select];
      cnt <= 3'h0;
      post <= 1'b0;
    end else if (ce) begin
      unlock <= next_unlock;
      select <= next_select;
      cnt <= next_cnt;
      post <= next_post;
    end
  end

  // blocked from unlock until the instruction after the select write
  assign block = unlock | post;
endmodule : ivp_unlock
`default_nettype wire

//--- rtl/ivp_top.sv
// ivp_top: interrupt vector placement with axi4-lite control registers
// assumes: core reports pc, instruction completion and pending interrupts on ref_clk
// Notes on behaviour
// - timer vectors at 0x50, 0x52, 0x54
// - programmed boot fuse starts at boot address
// - select set adds boot start to vectors
// - select bit 1; boot start from size fuses
// - block interrupts during unlock and one instruction
// - global interrupt enable flag left unchanged
// - unlock clears after four cycles or select
// - select changes only while unlocked
// - boot vectors plus app lock block app
// - app vectors plus boot lock block boot
`timescale 1ns/1ps
`default_nettype none
module ivp_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] core_pc,
  input wire logic core_instr_done,
  input wire logic global_int_en,
  input wire logic irq_pending,
  output logic [15:0] reset_addr,
  output logic [15:0] vector_base,
  output logic irq_take
);
  logic [7:0] fuse;
  logic [7:0] next_fuse;
  logic aw_held;
  logic next_aw_held;
  logic w_held;
  logic next_w_held;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  logic [15:0] next_reset_addr;
  logic [15:0] next_vector_base;
  logic next_irq_take;
  logic fuse_armed;
  logic next_fuse_armed;
  logic wr_fire;
  logic ctrl_wr;
  logic unlock;
  logic select;
  logic block;
  logic [15:0] boot_start;
  logic in_boot;
  logic lock_block;
  logic [15:0] fault_vec;
  logic next_awready;
  logic next_wready;
  logic next_arready;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ivp_pkg::ivp_off_ctrl) || (a == ivp_pkg::ivp_off_fuse) ||
              (a == ivp_pkg::ivp_off_vec) || (a == ivp_pkg::ivp_off_stat) ||
              (a == ivp_pkg::ivp_off_pc);
  endfunction : addr_ok

  function automatic logic [15:0] vec_at(input logic sel, input logic [15:0] base, input logic [15:0] nominal);
    vec_at = sel ? 16'(base + nominal) : nominal;
  endfunction : vec_at

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign ctrl_wr = wr_fire && (aw_addr == ivp_pkg::ivp_off_ctrl) && w_strb[0];

  ivp_unlock u_unlock (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .wr(ctrl_wr),
    .wdata(w_data[7:0]),
    .instr_done(core_instr_done),
    .unlock(unlock),
    .select(select),
    .block(block)
  );

  assign boot_start = ivp_pkg::ivp_boot_start(fuse[ivp_pkg::ivp_pos_boot_size_fuses +: 2]);
  assign in_boot = core_pc >= boot_start;
  // lock bits read 0 when programmed
  assign lock_block = (select && !fuse[ivp_pkg::ivp_bit_app_lock] && !in_boot) ||
                      (!select && !fuse[ivp_pkg::ivp_bit_boot_lock] && in_boot);
  assign fault_vec = vec_at(select, boot_start, ivp_pkg::ivp_vec_fault);

  // axi write and read channels
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp = s_axi_bresp;
    next_bvalid = s_axi_bvalid;
    next_fuse = fuse;
    next_fuse_armed = fuse_armed;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_ok(aw_addr) ? 2'h0 : 2'h2;
      if (aw_addr == ivp_pkg::ivp_off_fuse && w_strb[0] && !fuse_armed) begin
        next_fuse = w_data[7:0];
        next_fuse_armed = 1'b1;
      end
    end
    next_awready = !next_aw_held && !next_bvalid && !(s_axi_awvalid && s_axi_awready);
    next_wready = !next_w_held && !next_bvalid && !(s_axi_wvalid && s_axi_wready);
  end

  always_comb begin
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
      unique case (s_axi_araddr)
        ivp_pkg::ivp_off_ctrl: next_rdata = {30'h0000_0000, select, unlock};
        ivp_pkg::ivp_off_fuse: next_rdata = {24'h00_0000, fuse};
        ivp_pkg::ivp_off_vec: next_rdata = {vector_base, reset_addr};
        ivp_pkg::ivp_off_stat: next_rdata = {29'h0000_0000, lock_block, block, irq_take};
        ivp_pkg::ivp_off_pc: next_rdata = {fault_vec, boot_start};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_arready = !next_rvalid && !(s_axi_arvalid && s_axi_arready);
  end

  // placement and interrupt gate
  always_comb begin
    next_reset_addr = fuse[ivp_pkg::ivp_bit_boot_reset_fuse_fuse] ? ivp_pkg::ivp_flash_start : boot_start;
    next_vector_base = vec_at(select, boot_start, ivp_pkg::ivp_vec_first);
    // global enable is only read here, never written
    next_irq_take = irq_pending && global_int_en && !block && !lock_block;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bresp <= 2'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      fuse <= ivp_pkg::ivp_fuse_rst;
      fuse_armed <= 1'b0;
      reset_addr <= ivp_pkg::ivp_flash_start;
      vector_base <= ivp_pkg::ivp_vec_first;
      irq_take <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else if (ce) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bresp <= next_bresp;
      s_axi_bvalid <= next_bvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_rvalid <= next_rvalid;
      fuse <= next_fuse;
      fuse_armed <= next_fuse_armed;
      reset_addr <= next_reset_addr;
      vector_base <= next_vector_base;
      irq_take <= next_irq_take;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
    end
  end

  // relocated fault vector readback
  property p_vec_table;
    @(posedge ref_clk) disable iff (!nrst)
      ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == ivp_pkg::ivp_off_pc |=>
        s_axi_rdata[31:16] == ($past(select) ? 16'($past(boot_start) + 16'h0054) : 16'h0054);
  endproperty
  a_vec_table: assert property (p_vec_table) else $error("vector table misplaced");

  property p_reset_addr;
    @(posedge ref_clk) disable iff (!nrst)
      ce && $stable(fuse) ##1 ce |-> reset_addr ==
        ($past(fuse[ivp_pkg::ivp_bit_boot_reset_fuse_fuse]) ? 16'h0000 : $past(boot_start));
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("reset address wrong");

  property p_vec_base;
    @(posedge ref_clk) disable iff (!nrst)
      ce |=> vector_base == ($past(select) ? 16'($past(boot_start) + 16'h0002) : 16'h0002);
  endproperty
  a_vec_base: assert property (p_vec_base) else $error("vector base wrong");

  property p_vec_base_app;
    @(posedge ref_clk) disable iff (!nrst)
      ce && !select |=> vector_base == 16'h0002;
  endproperty
  a_vec_base_app: assert property (p_vec_base_app) else $error("app vector base wrong");

  property p_sel_locked;
    @(posedge ref_clk) disable iff (!nrst)
      !unlock |=> $stable(select);
  endproperty
  a_sel_locked: assert property (p_sel_locked) else $error("select changed while locked");

  sequence s_unlock_set;
    ce && ctrl_wr && w_data[0] && !unlock;
  endsequence
  property p_unlock_expire;
    @(posedge ref_clk) disable iff (!nrst)
      s_unlock_set ##1 (ce && !ctrl_wr) [*4] |=> !unlock;
  endproperty
  a_unlock_expire: assert property (p_unlock_expire) else $error("unlock not cleared");

  property p_block_unlock;
    @(posedge ref_clk) disable iff (!nrst)
      unlock |-> block ##1 !irq_take;
  endproperty
  a_block_unlock: assert property (p_block_unlock) else $error("irq during unlock");

  property p_unlock_window;
    @(posedge ref_clk) disable iff (!nrst)
      s_unlock_set |=> unlock [*4];
  endproperty
  a_unlock_window: assert property (p_unlock_window) else $error("unlock window short");

  property p_lock_gate;
    @(posedge ref_clk) disable iff (!nrst)
      ce && lock_block |=> !irq_take;
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("irq from locked section");

  property p_sel_bit;
    @(posedge ref_clk) disable iff (!nrst)
      ce && ctrl_wr && unlock && !w_data[0] |=> select == $past(w_data[1]) && !unlock;
  endproperty
  a_sel_bit: assert property (p_sel_bit) else $error("select write lost");

  property p_irq_pass;
    @(posedge ref_clk) disable iff (!nrst)
      ce && irq_pending && global_int_en && !block && !lock_block |=> irq_take;
  endproperty
  a_irq_pass: assert property (p_irq_pass) else $error("irq wrongly blocked");

  property p_ce_freeze;
    @(posedge ref_clk) disable iff (!nrst)
      !ce |=> $stable(unlock) && $stable(select) && $stable(irq_take);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");

  property p_post_block;
    @(posedge ref_clk) disable iff (!nrst)
      ce && core_instr_done && !unlock && !ctrl_wr |=> !block;
  endproperty
  a_post_block: assert property (p_post_block) else $error("block held past instruction");
endmodule : ivp_top
`default_nettype wire

//--- dv/ivp_core_model.sv
// ivp_core_model: stand-in for the processor core beside ivp_top
// assumes: bench commands pc jumps and instruction completions on ref_clk
`timescale 1ns/1ps
`default_nettype none
module ivp_core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic step,
  input wire logic load_pc,
  input wire logic [15:0] new_pc,
  input wire logic mask,
  output logic [15:0] core_pc,
  output logic core_instr_done,
  output logic global_int_en,
  output logic irq_pending
);
  // pc jumps on command, one done pulse per step
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      core_pc <= 16'h0000;
      core_instr_done <= 1'b0;
      global_int_en <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      core_pc <= load_pc ? new_pc : core_pc;
      core_instr_done <= step;
      global_int_en <= !mask; // flag owned by core only
      irq_pending <= 1'b1;
    end
  end
endmodule : ivp_core_model
`default_nettype wire

//--- dv/tb_interrupt_vector_placement.sv
// tb_interrupt_vector_placement: register level tests of ivp_top
// assumes: core model on the core side, axi4-lite master tasks here
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_vector_placement;
  localparam logic [15:0] boot_at = 16'h3f00;
  logic ref_clk, nrst, step, load_pc, ce, mask;
  logic [15:0] new_pc, core_pc, reset_addr, vector_base;
  logic core_instr_done, global_int_en, irq_pending, irq_take;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int n_mismatch, check_count;

  ivp_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_pc(core_pc),
    .core_instr_done(core_instr_done), .global_int_en(global_int_en), .irq_pending(irq_pending),
    .reset_addr(reset_addr), .vector_base(vector_base), .irq_take(irq_take));

  ivp_core_model core_u (.ref_clk(ref_clk), .nrst(nrst), .step(step), .load_pc(load_pc), .new_pc(new_pc),
    .mask(mask),
    .core_pc(core_pc), .core_instr_done(core_instr_done), .global_int_en(global_int_en),
    .irq_pending(irq_pending));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        rs = bresp;
      end
    end
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    logic got;
    got = 1'b0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
      end
    end
  endtask : rd_reg

  task automatic jump(input logic [15:0] p);
    @(posedge ref_clk);
    new_pc <= p;
    load_pc <= 1'b1;
    @(posedge ref_clk);
    load_pc <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : jump

  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch = n_mismatch + 1;
    give_verdict();
  end

  initial begin
    nrst = 1'b0;
    step = 1'b0;
    ce = 1'b1;
    mask = 1'b0;
    load_pc = 1'b0;
    new_pc = 16'h0000;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    n_mismatch = 0;
    check_count = 0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    jump(16'h3f10);
    rd_reg(ivp_pkg::ivp_off_vec);
    chk(rd, 32'h0002_0000);
    rd_reg(ivp_pkg::ivp_off_pc);
    chk(rd, 32'h0054_3f00);
    rd_reg(8'h20);
    chk({30'h0, rs}, 32'h0000_0002);
    chk(rd, 32'h0000_0000);
    // select write without unlock is ignored
    wr(ivp_pkg::ivp_off_ctrl, 32'h0000_0002);
    chk({30'h0, rs}, 32'h0000_0000);
    rd_reg(ivp_pkg::ivp_off_vec);
    chk(rd, 32'h0002_0000);
    // boot reset programmed, size 3, app lock programmed
    wr(ivp_pkg::ivp_off_fuse, 32'h0000_0016);
    rd_reg(ivp_pkg::ivp_off_vec);
    chk(rd, {16'h0002, boot_at});
    chk({vector_base, reset_addr}, {16'h0002, boot_at});
    chk({31'h0, irq_take}, 32'h0000_0001);
    // unlock then select, back to back
    wr(ivp_pkg::ivp_off_ctrl, 32'h0000_0001);
    wr(ivp_pkg::ivp_off_ctrl, 32'h0000_0002);
    chk({31'h0, irq_take}, 32'h0000_0000);
    rd_reg(ivp_pkg::ivp_off_vec);
    chk(rd, {boot_at + 16'h0002, boot_at});
    chk({vector_base, reset_addr}, {boot_at + 16'h0002, boot_at});
    rd_reg(ivp_pkg::ivp_off_pc);
    chk(rd, {boot_at + 16'h0054, boot_at});
    rd_reg(ivp_pkg::ivp_off_ctrl);
    chk(rd, 32'h0000_0002);
    chk({31'h0, irq_take}, 32'h0000_0000);
    @(posedge ref_clk);
    step <= 1'b1;
    @(posedge ref_clk);
    step <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq_take}, 32'h0000_0001);
    // core clears its global enable
    mask <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq_take}, 32'h0000_0000);
    mask <= 1'b0;
    // running from app with boot vectors and app lock
    jump(16'h0100);
    chk({31'h0, irq_take}, 32'h0000_0000);
    rd_reg(ivp_pkg::ivp_off_stat);
    chk(rd, 32'h0000_0004);
    jump(16'h3f10);
    // unlock left to expire
    wr(ivp_pkg::ivp_off_ctrl, 32'h0000_0001);
    @(posedge ref_clk);
    chk({31'h0, irq_take}, 32'h0000_0000);
    repeat (8) @(posedge ref_clk);
    chk({31'h0, irq_take}, 32'h0000_0001);
    rd_reg(ivp_pkg::ivp_off_ctrl);
    chk(rd, 32'h0000_0002);
    // clock enable low freezes the unlock window
    wr(ivp_pkg::ivp_off_ctrl, 32'h0000_0001);
    @(posedge ref_clk);
    ce <= 1'b0;
    repeat (8) @(posedge ref_clk);
    ce <= 1'b1;
    rd_reg(ivp_pkg::ivp_off_ctrl);
    chk(rd, 32'h0000_0003);
    wr(ivp_pkg::ivp_off_ctrl, 32'h0000_0000);
    rd_reg(ivp_pkg::ivp_off_vec);
    chk(rd, {boot_at + 16'h0002, boot_at});
    // second reset, fuses writable again
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk({vector_base, reset_addr}, 32'h0002_0000);
    rd_reg(ivp_pkg::ivp_off_ctrl);
    chk(rd, 32'h0000_0000);
    // boot lock programmed, app vectors
    wr(ivp_pkg::ivp_off_fuse, 32'h0000_0006);
    jump(16'h3f10);
    chk({31'h0, irq_take}, 32'h0000_0000);
    rd_reg(ivp_pkg::ivp_off_stat);
    chk(rd, 32'h0000_0004);
    jump(16'h0100);
    chk({31'h0, irq_take}, 32'h0000_0001);
    give_verdict();
  end
endmodule : tb_interrupt_vector_placement
`default_nettype wire
